// file: design/ssb_buf2.sv
// Two-entry valid/ready buffer used on the received-byte path.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module ssb_buf2 #(
   parameter int WIDTH = 8
) (
   input  wire logic             ref_clk_in,
   input  wire logic             reset_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic [1:0]       cnt_q, cnt_d;
   logic             rp_q, rp_d, wp_q, wp_d;
   logic             push, pop;

   assign in_ready_out  = (cnt_q != 2'h2);
   assign out_valid_out = (cnt_q != 2'h0);
   assign out_data_out  = mem_q[rp_q];
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;

   always_comb begin
      mem_d = mem_q;
      if (push) begin
         mem_d[wp_q] = in_data_in;
      end
      wp_d  = wp_q ^ push;
      rp_d  = rp_q ^ pop;
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         cnt_q    <= 2'h0;
         rp_q     <= 1'b0;
         wp_q     <= 1'b0;
      end else begin
         mem_q <= mem_d;
         cnt_q <= cnt_d;
         rp_q  <= rp_d;
         wp_q  <= wp_d;
      end
   end
endmodule // ssb_buf2

// file: design/ssb_cfg.svh
// Constants for the synchronous serial block: timing scale, clock-rate field values and reset levels.
// Assumes inclusion once per compile unit through the guard.
`ifndef SSB_CFG_SVH
`define SSB_CFG_SVH
`define SSB_REF_CLK_MHZ        40
`define SSB_CKS_NO_SYNC        4'h8
`define SSB_DIV_BASE           8'h04
`define SSB_SDA_LEVEL_RST      1'b1
`define SSB_SCL_MON_RST        1'b1
`define SSB_BITS_PER_BYTE      4'h8
// Monitoring time in half reference cycles (7.5 Tcyc = 15 halves)
`define SSB_MT_N_00            8'h0F
`define SSB_MT_N_01            8'h27
`define SSB_MT_N_10            8'h23
`define SSB_MT_N_11            8'h53
`define SSB_MT_T_00            8'h05
`define SSB_MT_T_01            8'h11
`define SSB_MT_T_10            8'h0F
`define SSB_MT_T_11            8'h27
`define SSB_MT_H_00            8'h23
`define SSB_MT_H_01            8'h53
`define SSB_MT_H_10            8'h4B
`define SSB_MT_H_11            8'hAB
`endif

// file: design/ssb_core.sv
// Notes on behaviour
// - Format select 1 selects clock synchronous serial
// - Master drives SCL; slave takes external clock
// - Data changes on fall, sampled on rise
// - Bit order picks MSB or LSB first
// - Idle SDA follows data output level bit
// - Transmit select write sets transmit empty
// - Holding byte moves to shifter, empty again
// - Master in receive starts receive clock
// - Full byte copied to holding, flag set
// - Eighth clock while full sets overrun, keeps; the code sets it only once both buffer entries hold a byte
// - Stop request ends after next byte, SCL high
// - Two latches, forward only on agreement
// - Check SCL after monitor time, stretch
// - Monitor time 7.5/19.5/17.5/41.5 cycles
// - Twice and half rate timing tables
// - Rate 1000b disables bit synchronisation
// - Late full clear: overrun, SCL keeps running
// - Control block reset clears engine state
// - Control block reset forces level bits high
//
// Synchronous serial transfer engine with noise filters and SCL bit synchronisation.
// Assumes control inputs come from software registers on ref_clk_in; pins are asynchronous.
`timescale 1ns/10ps
`include "ssb_cfg.svh"
module ssb_core
   import ssb_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input  wire logic             ref_clk_in,
   input  wire logic             reset_in,
   input  wire logic             unit_enable_in,
   input  wire logic             serial_format_select_in,
   input  wire logic             clock_master_select_in,
   input  wire logic             transmit_select_in,
   input  wire logic             bit_order_select_in,
   input  wire logic             receive_enable_in,
   input  wire logic             receive_stop_request_in,
   input  wire logic [3:0]       clock_rate_select_in,
   input  wire logic             half_rate_timing_in,
   input  wire logic             twice_rate_timing_in,
   input  wire logic [DIV_W-1:0] half_period_in,
   input  wire logic             data_output_level_wr_in,
   input  wire logic             data_output_level_in,
   input  wire logic             control_block_reset_in,
   input  wire logic             tx_write_in,
   input  wire ssb_byte_t        tx_data_in,
   input  wire logic             rx_read_in,
   input  wire logic             overrun_clear_in,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  scl_out,
   output logic                  scl_oe_out,
   output logic                  sda_out,
   output logic                  sda_oe_out,
   output logic                  transmit_empty_flag_out,
   output logic                  receive_full_flag_out,
   output logic                  overrun_flag_out,
   output logic                  data_output_level_out,
   output logic                  scl_monitor_flag_out,
   output ssb_byte_t             rx_data_out,
   output logic                  receive_interrupt_out
);
   // Pin filters: sync pair, then two-latch agreement filter
   logic [1:0] scl_s_q, sda_s_q, scl_l_q, sda_l_q;
   logic       scl_f_q, sda_f_q, scl_prev_q;
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         scl_s_q    <= 2'h3;
         sda_s_q    <= 2'h3;
         scl_l_q    <= 2'h3;
         sda_l_q    <= 2'h3;
         scl_f_q    <= 1'b1;
         sda_f_q    <= 1'b1;
         scl_prev_q <= 1'b1;
      end else begin
         scl_s_q    <= {scl_s_q[0], scl_in};
         sda_s_q    <= {sda_s_q[0], sda_in};
         scl_l_q    <= {scl_l_q[0], scl_s_q[1]};
         sda_l_q    <= {sda_l_q[0], sda_s_q[1]};
         if (scl_l_q[0] == scl_l_q[1]) scl_f_q <= scl_l_q[1];
         if (sda_l_q[0] == sda_l_q[1]) sda_f_q <= sda_l_q[1];
         scl_prev_q <= scl_f_q;
      end
   end
   wire scl_rise = scl_f_q & ~scl_prev_q;
   wire scl_fall = ~scl_f_q & scl_prev_q;

   function automatic logic [7:0] mt_halves(input logic h, input logic t, input logic [1:0] k);
      logic [7:0] r;
      r = 8'h00;
      if (t) begin
         case (k)
            2'h0: r = `SSB_MT_T_00;
            2'h1: r = `SSB_MT_T_01;
            2'h2: r = `SSB_MT_T_10;
            default: r = `SSB_MT_T_11;
         endcase
      end else if (h) begin
         case (k)
            2'h0: r = `SSB_MT_H_00;
            2'h1: r = `SSB_MT_H_01;
            2'h2: r = `SSB_MT_H_10;
            default: r = `SSB_MT_H_11;
         endcase
      end else begin
         case (k)
            2'h0: r = `SSB_MT_N_00;
            2'h1: r = `SSB_MT_N_01;
            2'h2: r = `SSB_MT_N_10;
            default: r = `SSB_MT_N_11;
         endcase
      end
      return r;
   endfunction
   // Half-cycle figures round up to whole reference cycles
   wire [7:0] mt_halves_v = mt_halves(half_rate_timing_in, twice_rate_timing_in,
                                      clock_rate_select_in[3:2]);
   wire [7:0] mt_cycles   = (mt_halves_v + 8'h01) >> 1;
   wire       sync_off    = (clock_rate_select_in == `SSB_CKS_NO_SYNC);

   // Engine state
   ssb_clk_e   st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic [3:0] bit_q, bit_d;
   ssb_byte_t  sh_q, sh_d, txh_q, txh_d;
   logic       txv_q, txv_d, tde_q, tde_d, ovr_q, ovr_d;
   logic       sdo_q, sdo_d, scl_monitor_flag_q, scl_monitor_flag_d, scl_drv_q, scl_drv_d;
   logic       lvl_q, lvl_d, active_q, active_d, stop_q, stop_d, trs_q;
   logic       rx_push, rx_ready, rx_valid;
   ssb_byte_t  rx_byte;

   wire run   = unit_enable_in & serial_format_select_in;
   wire clock_master_select   = clock_master_select_in;
   wire rx_on = ~transmit_select_in & receive_enable_in;
   wire [DIV_W-1:0] half_p = (half_period_in == '0) ? DIV_W'(`SSB_DIV_BASE) : half_period_in;
   wire out_bit = bit_order_select_in ? sh_q[0] : sh_q[7];
   wire [3:0] eight = `SSB_BITS_PER_BYTE;
   // Full receive buffer means the byte in flight cannot land
   wire full_block = ~rx_ready;

   always_comb begin
      st_d = st_q; cnt_d = cnt_q; bit_d = bit_q; sh_d = sh_q; txh_d = txh_q;
      txv_d = txv_q; tde_d = tde_q; ovr_d = ovr_q; sdo_d = sdo_q; scl_monitor_flag_d = scl_monitor_flag_q;
      scl_drv_d = scl_drv_q; lvl_d = lvl_q; active_d = active_q; stop_d = stop_q;
      rx_push = 1'b0;
      if (data_output_level_wr_in & ~active_q) lvl_d = data_output_level_in;
      if (transmit_select_in & ~trs_q) tde_d = 1'b1;
      if (tx_write_in) begin
         txh_d = tx_data_in;
         txv_d = 1'b1;
         tde_d = 1'b0;
      end
      if (overrun_clear_in) ovr_d = 1'b0;
      scl_monitor_flag_d = scl_f_q;
      // Load shifter when idle and a byte waits
      if (run & transmit_select_in & txv_q & ~active_q) begin
         sh_d = txh_q; txv_d = 1'b0; tde_d = 1'b1;
         active_d = 1'b1; bit_d = 4'h0;
         sdo_d = bit_order_select_in ? txh_q[0] : txh_q[7];
      end
      if (run & rx_on & ~active_q & ~stop_q & (clock_master_select | scl_fall)) begin
         active_d = 1'b1; bit_d = 4'h0;
      end
      if (receive_stop_request_in & ~stop_q & active_q & rx_on) stop_d = 1'b1;
      if (~receive_stop_request_in) stop_d = 1'b0;
      // Master clock generator with bit synchronisation
      case (st_q)
         SSB_IDLE: begin
            scl_drv_d = 1'b0;
            if (run & clock_master_select & active_d) begin st_d = SSB_LOW; cnt_d = 8'h00; scl_drv_d = 1'b1; end
         end
         SSB_LOW: begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q >= 8'(half_p)) begin st_d = SSB_HIGH; cnt_d = 8'h00; scl_drv_d = 1'b0; end
         end
         SSB_HIGH: begin
            cnt_d = cnt_q + 8'h01;
            if (~sync_off & (cnt_q + 8'h01 == mt_cycles) & ~scl_f_q) st_d = SSB_CHECK;
            else if (cnt_q >= 8'(half_p)) begin
               cnt_d = 8'h00;
               if (active_q) begin st_d = SSB_LOW; scl_drv_d = 1'b1; end
               else st_d = SSB_IDLE;
            end
         end
         SSB_CHECK: begin
            // Falling edge waits until SCL is really seen high
            if (scl_f_q) st_d = SSB_HIGH;
         end
         default: st_d = SSB_IDLE;
      endcase
      if (~run | ~clock_master_select) begin st_d = SSB_IDLE; scl_drv_d = 1'b0; end
      // Shift on the filtered pin edges, master or external clock
      if (active_q & scl_rise) begin
         sh_d = bit_order_select_in ? {sda_f_q, sh_q[7:1]} : {sh_q[6:0], sda_f_q};
         bit_d = bit_q + 4'h1;
         if ((bit_q + 4'h1) == eight) begin
            active_d = 1'b0;
            if (rx_on) begin
               if (full_block) ovr_d = 1'b1;
               else rx_push = 1'b1;
               if (~stop_q & ~receive_stop_request_in & clock_master_select) active_d = 1'b1;
               bit_d = 4'h0;
            end else if (txv_q & transmit_select_in) begin
               sh_d = txh_q; txv_d = 1'b0; tde_d = 1'b1; active_d = 1'b1; bit_d = 4'h0;
            end
         end
      end
      if (active_q & scl_fall & transmit_select_in) sdo_d = out_bit;
      if (~active_q & ~active_d) sdo_d = lvl_q;
      if (control_block_reset_in) begin
         st_d = SSB_IDLE; active_d = 1'b0; bit_d = 4'h0; scl_drv_d = 1'b0;
         lvl_d = `SSB_SDA_LEVEL_RST; scl_monitor_flag_d = `SSB_SCL_MON_RST; sdo_d = `SSB_SDA_LEVEL_RST;
         txv_d = 1'b0; stop_d = 1'b0;
         if (transmit_select_in) tde_d = 1'b1;
      end
      if (tx_write_in & ~control_block_reset_in) tde_d = 1'b0;
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         st_q <= SSB_IDLE; cnt_q <= 8'h00; bit_q <= 4'h0; sh_q <= 8'h00; txh_q <= 8'h00;
         txv_q <= 1'b0; tde_q <= 1'b0; ovr_q <= 1'b0; sdo_q <= `SSB_SDA_LEVEL_RST;
         scl_monitor_flag_q <= `SSB_SCL_MON_RST; scl_drv_q <= 1'b0; lvl_q <= `SSB_SDA_LEVEL_RST;
         active_q <= 1'b0; stop_q <= 1'b0; trs_q <= 1'b0;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; bit_q <= bit_d; sh_q <= sh_d; txh_q <= txh_d;
         txv_q <= txv_d; tde_q <= tde_d; ovr_q <= ovr_d; sdo_q <= sdo_d;
         scl_monitor_flag_q <= scl_monitor_flag_d; scl_drv_q <= scl_drv_d; lvl_q <= lvl_d;
         active_q <= active_d; stop_q <= stop_d; trs_q <= transmit_select_in;
      end
   end

   assign rx_byte = sh_d;
   ssb_buf2 #(.WIDTH(8)) u_rxbuf (
      .ref_clk_in    (ref_clk_in),
      .reset_in      (reset_in),
      .in_valid_in   (rx_push),
      .in_ready_out  (rx_ready),
      .in_data_in    (rx_byte),
      .out_valid_out (rx_valid),
      .out_ready_in  (rx_read_in),
      .out_data_out  (rx_data_out)
   );

   assign scl_out                 = 1'b0;
   assign scl_oe_out              = scl_drv_q;
   assign sda_out                 = sdo_q;
   assign sda_oe_out              = run & (transmit_select_in | ~rx_on);
   assign transmit_empty_flag_out = tde_q;
   assign receive_full_flag_out   = rx_valid;
   assign receive_interrupt_out   = rx_valid & receive_enable_in;
   assign overrun_flag_out        = ovr_q;
   assign data_output_level_out   = lvl_q;
   assign scl_monitor_flag_out    = scl_monitor_flag_q;
endmodule // ssb_core

// file: design/ssb_pkg.sv
// Types for the synchronous serial block.
// Assumes nothing beyond a SystemVerilog compile.
package ssb_pkg;
   typedef enum logic [1:0] {
      SSB_IDLE  = 2'b00,
      SSB_LOW   = 2'b01,
      SSB_HIGH  = 2'b10,
      SSB_CHECK = 2'b11
   } ssb_clk_e;
   typedef logic [7:0] ssb_byte_t;
endpackage

// file: verification/ssb_core_bench.sv
// Bench for ssb_core: the main process drives controls and queues expected bytes.
// Assumes ssb_peer on the wires and ssb_core_props bound to the core.
`timescale 1ns/10ps
module ssb_core_bench;
   import ssb_pkg::*;
   logic       clk = 0, rst = 1, en = 0, fmt = 0, clock_master_select = 0, transmit_select = 0, lsb = 0, re = 0, stp = 0;
   logic       lvl_wr = 0, lvl = 1, cbr = 0, txw = 0, rd = 0, oclr = 0, auto_rd = 1, ext_go = 0;
   logic [3:0] cks = 0;
   ssb_byte_t  txd = 0, b, rxd, cap;
   logic [7:0] nb;
   wire        scl, sda, scl_oe, sda_o, sda_oe, tde, rdf, ovr, lvlq, sclm, irq, scl_monitor_flag;
   int         err_count = 0, compares = 0, seed = 32'ha404, n0;
   ssb_byte_t  txq[$], rxq[$];
   ssb_core u_dut (.ref_clk_in(clk), .reset_in(rst), .unit_enable_in(en), .serial_format_select_in(fmt),
      .clock_master_select_in(clock_master_select), .transmit_select_in(transmit_select), .bit_order_select_in(lsb),
      .receive_enable_in(re), .receive_stop_request_in(stp), .clock_rate_select_in(cks),
      .half_rate_timing_in(1'b0), .twice_rate_timing_in(1'b0), .half_period_in(8'h09),
      .data_output_level_wr_in(lvl_wr), .data_output_level_in(lvl), .control_block_reset_in(cbr),
      .tx_write_in(txw), .tx_data_in(txd), .rx_read_in(rd), .overrun_clear_in(oclr), .scl_in(scl),
      .sda_in(sda), .scl_out(scl_monitor_flag), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
      .transmit_empty_flag_out(tde), .receive_full_flag_out(rdf), .overrun_flag_out(ovr),
      .data_output_level_out(lvlq), .scl_monitor_flag_out(sclm), .rx_data_out(rxd),
      .receive_interrupt_out(irq));
   ssb_peer u_peer (.scl_oe_in(scl_oe), .sda_core_in(sda_o), .sda_oe_in(sda_oe), .ext_go_in(ext_go),
      .scl_out(scl), .sda_out(sda), .cap_out(cap), .nb_out(nb));
   initial forever #12.5 clk = ~clk;
   task automatic end_of_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input ssb_byte_t got, input ssb_byte_t exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   function automatic bit flg(input int w);
      case (w)
         0: return tde === 1'b1;
         1: return ovr === 1'b1;
         2: return rxq.size() <= 1;
         default: return txq.size() == 0 && rxq.size() == 0;
      endcase
   endfunction
   task automatic wt(input int w);
      for (int i = 0; i < 3000 && !flg(w); i++) @(posedge clk);
      if (!flg(w)) chk(8'h00, 8'h01);
   endtask
   // Peer byte n carries A5 plus n steps of 3C
   function automatic ssb_byte_t pb(input int n);
      return 8'hA5 + 8'h3C * n[7:0];
   endfunction
   always @(posedge clk) begin
      rd <= 1'b0;
      if (rdf === 1'b1 && auto_rd && !rd) begin
         rd <= 1'b1;
         chk(rxd, rxq.size() ? rxq.pop_front() : ~rxd);
      end
   end
   always @(nb) if (transmit_select === 1'b1) chk(cap, txq.size() ? txq.pop_front() : ~cap);
   initial begin
      cyc(20000);
      err_count++;
      end_of_test();
   end
   initial begin
      cyc(8);
      rst <= 0;
      cyc(1);
      chk({3'h0, lvlq, sclm, tde, rdf, ovr}, 8'h18);
      en <= 1;
      fmt <= 1;
      cks <= 4'($random(seed));
      cyc(1);
      lvl <= 0;
      lvl_wr <= 1;
      cyc(1);
      lvl_wr <= 0;
      cyc(3);
      chk({6'h00, sda, lvlq}, 8'h00);
      cbr <= 1;
      cyc(1);
      cbr <= 0;
      cyc(2);
      chk({4'h0, lvlq, sclm, sda, scl_oe}, 8'h0E);
      for (int o = 0; o < 2; o++) begin
         lsb <= o[0];
         transmit_select <= 1;
         clock_master_select <= 1;
         cyc(2);
         chk({7'h00, tde}, 8'h01);
         repeat (3) begin
            b = $random(seed);
            txq.push_back(o ? ssb_byte_t'({<<{b}}) : b);
            wt(0);
            txd <= b;
            txw <= 1;
            cyc(1);
            txw <= 0;
            cyc(2);
         end
         wt(3);
         transmit_select <= 0;
         clock_master_select <= 0;
         // Let the filtered last rise of the byte land before the next mode starts
         cyc(20);
      end
      for (int i = 0; i < 3; i++) rxq.push_back(pb(nb + i));
      re <= 1;
      clock_master_select <= 1;
      // Peer shifts MSB first, so receive must not keep the LSB-first setting of the last loop
      lsb <= 0;
      wt(2);
      stp <= 1;
      wt(3);
      cyc(200);
      chk({5'h00, scl_oe, scl, rdf}, 8'h02);
      stp <= 0;
      re <= 0;
      clock_master_select <= 0;
      cyc(2);
      rxq.push_back(pb(nb));
      re <= 1;
      ext_go <= 1;
      cyc(1);
      ext_go <= 0;
      wt(3);
      re <= 0;
      auto_rd <= 0;
      n0 = nb;
      cyc(2);
      re <= 1;
      clock_master_select <= 1;
      wt(1);
      chk(rxd, pb(n0));
      chk({6'h00, irq, rdf}, 8'h03);
      stp <= 1;
      rxq.push_back(pb(n0));
      rxq.push_back(pb(n0 + 1));
      cyc(400);
      auto_rd <= 1;
      wt(3);
      oclr <= 1;
      cyc(1);
      oclr <= 0;
      cyc(2);
      chk({7'h00, ovr}, 8'h00);
      end_of_test();
   end
endmodule // ssb_core_bench
bind ssb_core ssb_core_props u_props (.*);

// file: verification/ssb_core_props.sv
// Concurrent checks on the ports of ssb_core.
// Assumes the bench ties half_period_in to 9, so an SCL low phase lasts 10 cycles.
`timescale 1ns/10ps
module ssb_core_props
   import ssb_pkg::*;
(
   input wire logic      ref_clk_in,
   input wire logic      reset_in,
   input wire logic      unit_enable_in,
   input wire logic      serial_format_select_in,
   input wire logic      clock_master_select_in,
   input wire logic      transmit_select_in,
   input wire logic      control_block_reset_in,
   input wire logic      tx_write_in,
   input wire logic      rx_read_in,
   input wire logic      scl_out,
   input wire logic      scl_oe_out,
   input wire logic      transmit_empty_flag_out,
   input wire logic      receive_full_flag_out,
   input wire logic      overrun_flag_out,
   input wire logic      data_output_level_out,
   input wire logic      scl_monitor_flag_out,
   input wire ssb_byte_t rx_data_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);
   scl_od_a: assert property (!scl_out)
      else $error("core drives SCL high");
   cbr_level_a: assert property (control_block_reset_in |=> data_output_level_out && scl_monitor_flag_out)
      else $error("level bits not forced high by block reset");
   tde_set_a: assert property ($rose(transmit_select_in) && unit_enable_in |-> ##[1:2] transmit_empty_flag_out)
      else $error("transmit empty not set on transmit select");
   tde_refill_a: assert property (tx_write_in |=> !transmit_empty_flag_out ##[1:400] transmit_empty_flag_out)
      else $error("transmit empty not raised again after a write");
   ovr_keep_a: assert property ($rose(overrun_flag_out) |-> $stable(rx_data_out) && receive_full_flag_out)
      else $error("received byte changed on overrun");
   full_drop_a: assert property ($fell(receive_full_flag_out) |-> $past(rx_read_in) || $past(control_block_reset_in))
      else $error("full flag dropped without a read");
   slave_noclk_a: assert property (serial_format_select_in && !clock_master_select_in
      && !$past(clock_master_select_in) |-> !scl_oe_out)
      else $error("clock slave pulls SCL");
   scl_low_a: assert property (serial_format_select_in && $rose(scl_oe_out)
      |-> scl_oe_out[*8] ##1 scl_oe_out[*2] ##1 !scl_oe_out)
      else $error("SCL low phase not ten cycles");
endmodule // ssb_core_props

// file: verification/ssb_peer.sv
// Far-side serial device on the SCL and SDA wires of ssb_core.
// Assumes open-drain SCL with pull-up; the peer shifts MSB first and counts bytes.
`timescale 1ns/10ps
module ssb_peer (
   input  wire logic scl_oe_in,
   input  wire logic sda_core_in,
   input  wire logic sda_oe_in,
   input  wire logic ext_go_in,
   output logic      scl_out,
   output logic      sda_out,
   output logic [7:0] cap_out,
   output logic [7:0] nb_out
);
   logic       ext_low = 1'b0;
   logic       d = 1'b1;
   logic [7:0] sh = 8'h00;
   logic [7:0] cur = 8'hA5;
   int         cnt = 0;
   assign scl_out = !scl_oe_in && !ext_low;
   assign sda_out = sda_oe_in ? sda_core_in : d;
   initial nb_out = 8'h00;
   // External clock runs only for the eight bits of a frame
   always @(posedge ext_go_in) begin
      repeat (8) begin
         ext_low = 1'b1;
         #100;
         ext_low = 1'b0;
         #100;
      end
   end
   // Time-zero edges come from the wire settling, not from a clock
   always @(negedge scl_out) if ($time > 0) d = cur[7 - cnt];
   always @(posedge scl_out) begin
      if ($time > 0) begin
         sh = {sh[6:0], sda_out};
         cnt++;
         if (cnt == 8) begin
            cnt = 0;
            cap_out = sh;
            cur = cur + 8'h3C;
            nb_out = nb_out + 8'h01;
         end
      end
   end
endmodule // ssb_peer
